// [include/hfs_pkg.sv]
// Constants for the HDLC frame closure status block
package hfs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CLOSED = 8'h08;
  localparam logic [7:0] OFS_MATCH = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_MAXLEN = 8'h14;
  // ==========================================================
  // Status word layout
  localparam int BIT_FLAGS = 31;
  localparam int BIT_IDLE = 30;
  localparam int RX_CL_MSB = 27;
  localparam int RX_CL_W = 10;
  localparam int TX_CL_MSB = 15;
  localparam int TX_CL_W = 2;
  // Index inside the receive closure vector
  localparam int CL_M1 = 9;
  localparam int CL_M2 = 8;
  localparam int CL_M3 = 7;
  localparam int CL_M4 = 6;
  localparam int CL_NORMAL = 5;
  localparam int CL_CRC = 4;
  localparam int CL_OVR = 3;
  localparam int CL_ALN = 2;
  localparam int CL_LONG = 1;
  localparam int CL_ABT = 0;
  // Index inside the transmit closure vector
  localparam int CL_CTS = 1;
  localparam int CL_UND = 0;
  // ==========================================================
  // Control and closed-flag register bits
  localparam int CTL_CTS_GATE = 0;
  localparam int CTL_WIDE_ONE = 1;
  localparam int CTL_WIDE_TWO = 2;
  localparam int CTL_W = 3;
  localparam int ACK_RX = 0;
  localparam int ACK_TX = 1;
  // ==========================================================
  // Reset values and line constants
  localparam logic [CTL_W-1:0] RST_CTRL = 3'h0;
  localparam logic [31:0] RST_MATCH = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [15:0] RST_MAXLEN = 16'hFFFF;
  localparam logic [7:0] FLAG_PATTERN = 8'h7E;
  localparam logic [3:0] ONES_ABORT = 4'h8;
  localparam logic [3:0] ONES_MAX = 4'hF;
endpackage

// [include/hfs_match_if.sv]
// Interface between the status block and its address comparator
`timescale 1ns/1ns
`default_nettype none
interface hfs_match_if;
  logic [7:0] first_byte;
  logic [7:0] second_byte;
  logic [31:0] match;
  logic [31:0] mask;
  logic wide_one;
  logic wide_two;
  logic [3:0] hit;
  modport calc (
    input first_byte, second_byte, match, mask, wide_one, wide_two,
    output hit
  );
  modport user (
    output first_byte, second_byte, match, mask, wide_one, wide_two,
    input hit
  );
endinterface
`default_nettype wire

// [verilog/hfs_addr_match.sv]
// Masked address comparator for the four match bytes
`timescale 1ns/1ns
`default_nettype none
module hfs_addr_match (
  hfs_match_if.calc m
);
  logic [3:0] eq_first;
  logic [3:0] eq_second;
  // ==========================================================
  // Per-byte compare, masked bits ignored
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_cmp
      assign eq_first[k] = ((m.first_byte ^ m.match[31-8*k -: 8])
        & ~m.mask[31-8*k -: 8]) == 8'h00; // see RL20
      assign eq_second[k] = ((m.second_byte ^ m.match[31-8*k -: 8])
        & ~m.mask[31-8*k -: 8]) == 8'h00; // see RL20
    end
  endgenerate
  // ==========================================================
  // Wide mode replaces the single-byte test of byte one and three
  assign m.hit[3] = m.wide_one ? (eq_first[0] & eq_second[1]) : eq_first[0]; // see RL3 see RL4
  assign m.hit[2] = eq_first[1]; // see RL5
  assign m.hit[1] = m.wide_two ? (eq_first[2] & eq_second[3]) : eq_first[2]; // see RL6
  assign m.hit[0] = eq_first[3]; // see RL7
endmodule
`default_nettype wire

// [verilog/hfs_status.sv]
// HDLC frame closure and line status block with its register port
// Function
// RL1 - Flag status bit high while idle receiver sees continuous flags.
// RL2 - Idle status bit high while receiver inactive and line all ones.
// RL3 - Match-one bit set when first byte equals match byte one.
// RL4 - Wide mode one: first two bytes against match bytes one and two.
// RL5 - Match-two bit set when first byte equals match byte two.
// RL6 - Match-three bit on byte three, or bytes three and four wide.
// RL7 - Match-four bit set when first byte equals match byte four.
// RL8 - Normal bit set when frame closed with no error.
// RL9 - CRC bit set when frame failed its CRC check.
// RL10 - Overrun bit set when receive FIFO overflowed during frame.
// RL11 - Alignment bit set when frame ends off a byte boundary.
// RL12 - Oversize bit set when frame longer than maximum length.
// RL13 - Abort bit set on eight consecutive ones inside a frame.
// RL14 - CTS loss aborts transmit frame and sets its closure bit.
// RL15 - CTS loss acts only while the CTS gate enable is set.
// RL16 - Underrun bit set when transmit frame ran out of data.
// RL17 - Firmware trusts receive closure bits only while receive closed.
// RL18 - Firmware trusts transmit closure bits only while transmit closed.
// RL19 - Firmware reads status before ack, acks before next frame.
// RL20 - Masked bit positions take no part in address compare.
// RL21 - Closure bits stay stable from closed flag until its ack.
// RL22 - Closure and line status bits ignore firmware writes.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module hfs_status
  import hfs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [31:0] o_rdata,
  input wire logic i_rx_bit_valid,
  input wire logic i_rx_bit,
  input wire logic i_rx_active,
  input wire logic i_rx_byte_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_frame_end,
  input wire logic [2:0] i_rx_residue,
  input wire logic i_rx_crc_bad,
  input wire logic i_rx_overrun,
  input wire logic i_tx_active,
  input wire logic i_cts,
  input wire logic i_tx_frame_end,
  input wire logic i_tx_underrun,
  output logic o_tx_abort,
  output logic o_rx_buffer_closed_flag,
  output logic o_tx_buffer_closed_flag
);
  logic [CTL_W-1:0] ctrl;
  logic [31:0] match_reg;
  logic [31:0] mask_reg;
  logic [15:0] max_len;
  logic [7:0] line_sh;
  logic [3:0] ones_cnt;
  logic [3:0] next_ones;
  logic flags_st;
  logic idle_st;
  logic [15:0] byte_cnt;
  logic [7:0] first_byte;
  logic [7:0] second_byte;
  logic ovr_acc;
  logic long_acc;
  logic abort_evt;
  logic rx_close;
  logic ack_rx;
  logic ack_tx;
  logic rx_latch;
  logic tx_latch;
  logic cts_loss;
  logic tx_close;
  logic rx_closed_flag;
  logic tx_closed_flag;
  logic [RX_CL_W-1:0] rx_cl;
  logic [TX_CL_W-1:0] tx_cl;
  logic [31:0] stat_word;
  logic [31:0] next_rdata;
  hfs_match_if mif ();

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ==========================================================
  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl <= RST_CTRL;
      match_reg <= RST_MATCH;
      mask_reg <= RST_MASK;
      max_len <= RST_MAXLEN;
    end else if (i_ce && i_we) begin
      case (i_addr)
        OFS_CTRL: ctrl <= i_wdata[CTL_W-1:0];
        OFS_MATCH: match_reg <= i_wdata;
        OFS_MASK: mask_reg <= i_wdata;
        OFS_MAXLEN: max_len <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Write-one acknowledge of the closed flags
  assign ack_rx = i_we && (i_addr == OFS_CLOSED) && i_wdata[ACK_RX];
  assign ack_tx = i_we && (i_addr == OFS_CLOSED) && i_wdata[ACK_TX];

  // ==========================================================
  // Line monitor: flags, idle and abort runs
  assign next_ones = !i_rx_bit ? 4'h0 : (ones_cnt == ONES_MAX) ? ONES_MAX : ones_cnt + 4'h1;
  assign abort_evt = i_rx_active && i_rx_bit_valid && (next_ones == ONES_ABORT); // see RL13

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      line_sh <= 8'h00;
      ones_cnt <= 4'h0;
    end else if (i_ce && i_rx_bit_valid) begin
      line_sh <= {line_sh[6:0], i_rx_bit};
      ones_cnt <= next_ones;
    end
  end

  // Any run of seven ones breaks the flag pattern
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flags_st <= 1'b0;
    end else if (i_ce) begin
      if (i_rx_active) begin
        flags_st <= 1'b0; // see RL1
      end else if (i_rx_bit_valid && ({line_sh[6:0], i_rx_bit} == FLAG_PATTERN)) begin
        flags_st <= 1'b1; // see RL1
      end else if (i_rx_bit_valid && next_ones >= 4'h7) begin
        flags_st <= 1'b0; // see RL1
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idle_st <= 1'b0;
    end else if (i_ce) begin
      idle_st <= !i_rx_active && (i_rx_bit_valid ? next_ones : ones_cnt) >= ONES_ABORT; // see RL2
    end
  end

  AST_FLAGS_OFF: assert property (i_ce && i_rx_active |=> !flags_st) // see RL1
    else $error("flag status set while receiver active");
  AST_IDLE_OFF: assert property (i_ce && i_rx_active |=> !idle_st) // see RL2
    else $error("idle status set while receiver active");

  // ==========================================================
  // Per-frame accumulation
  assign rx_close = i_rx_frame_end || abort_evt;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      byte_cnt <= 16'h0000;
      first_byte <= 8'h00;
      second_byte <= 8'h00;
    end else if (i_ce) begin
      if (rx_close) begin
        byte_cnt <= 16'h0000;
      end else if (i_rx_byte_valid) begin
        if (byte_cnt == 16'h0000) begin
          first_byte <= i_rx_byte;
        end
        if (byte_cnt == 16'h0001) begin
          second_byte <= i_rx_byte;
        end
        if (byte_cnt != 16'hFFFF) begin
          byte_cnt <= byte_cnt + 16'h0001;
        end
      end
    end
  end

  // Errors seen mid-frame stick until the frame closes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ovr_acc <= 1'b0;
      long_acc <= 1'b0;
    end else if (i_ce) begin
      if (rx_close) begin
        ovr_acc <= 1'b0;
        long_acc <= 1'b0;
      end else begin
        if (i_rx_overrun) begin
          ovr_acc <= 1'b1; // see RL10
        end
        if (i_rx_byte_valid && byte_cnt >= max_len) begin
          long_acc <= 1'b1; // see RL12
        end
      end
    end
  end

  // ==========================================================
  // Address comparator
  assign mif.first_byte = first_byte;
  assign mif.second_byte = second_byte;
  assign mif.match = match_reg;
  assign mif.mask = mask_reg;
  assign mif.wide_one = ctrl[CTL_WIDE_ONE];
  assign mif.wide_two = ctrl[CTL_WIDE_TWO];

  hfs_addr_match u_match (
    .m(mif.calc)
  );

  // ==========================================================
  // Receive closure latch; a close while the flag stands and no ack comes in the same cycle is dropped
  assign rx_latch = i_ce && rx_close && (!rx_closed_flag || ack_rx); // see RL21

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_cl <= '0;
    end else if (rx_latch) begin
      rx_cl[CL_M1 -: 4] <= mif.hit; // see RL3 see RL5 see RL6 see RL7
      rx_cl[CL_NORMAL] <= !abort_evt && !i_rx_crc_bad && !ovr_acc && !i_rx_overrun
        && !long_acc && (i_rx_residue == 3'h0); // see RL8
      rx_cl[CL_CRC] <= !abort_evt && i_rx_crc_bad; // see RL9
      rx_cl[CL_OVR] <= ovr_acc || i_rx_overrun; // see RL10
      rx_cl[CL_ALN] <= !abort_evt && (i_rx_residue != 3'h0); // see RL11
      rx_cl[CL_LONG] <= long_acc; // see RL12
      rx_cl[CL_ABT] <= abort_evt; // see RL13
    end
  end

  // Set beats a same-cycle acknowledge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_closed_flag <= 1'b0;
    end else if (i_ce) begin
      if (rx_latch) begin
        rx_closed_flag <= 1'b1;
      end else if (ack_rx) begin
        rx_closed_flag <= 1'b0;
      end
    end
  end

  AST_MATCH_HIT: assert property (rx_latch |=> rx_cl[CL_M1 -: 4] == $past(mif.hit)) // see RL3
    else $error("match closure bits differ from comparator");
  AST_NORMAL: assert property (rx_latch && i_rx_frame_end && !abort_evt && !i_rx_crc_bad
    && !ovr_acc && !i_rx_overrun && !long_acc && i_rx_residue == 3'h0
    |=> rx_cl[CL_NORMAL] && rx_closed_flag) // see RL8
    else $error("clean frame not closed as normal");
  AST_CRC: assert property (rx_latch && !abort_evt && i_rx_crc_bad
    |=> rx_cl[CL_CRC] && !rx_cl[CL_NORMAL]) // see RL9
    else $error("crc error not reported");
  AST_ALIGN: assert property (rx_latch && !abort_evt && i_rx_residue != 3'h0
    |=> rx_cl[CL_ALN] && !rx_cl[CL_NORMAL]) // see RL11
    else $error("alignment error not reported");
  AST_ABORT: assert property (i_ce && i_rx_active && i_rx_bit_valid && i_rx_bit
    && ones_cnt == 4'h7 && !rx_closed_flag |=> rx_cl[CL_ABT] && rx_closed_flag) // see RL13
    else $error("eighth one did not abort the frame");
  AST_RX_HOLD: assert property (rx_closed_flag && !(i_ce && ack_rx)
    |=> $stable(rx_cl) && rx_closed_flag) // see RL21
    else $error("receive closure bits changed before ack");

  // ==========================================================
  // Transmit closure
  assign cts_loss = ctrl[CTL_CTS_GATE] && i_tx_active && !i_cts; // see RL15
  assign o_tx_abort = cts_loss; // see RL14
  assign tx_close = cts_loss || i_tx_underrun || i_tx_frame_end;
  assign tx_latch = i_ce && tx_close && (!tx_closed_flag || ack_tx); // see RL21

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_cl <= '0;
    end else if (tx_latch) begin
      tx_cl[CL_CTS] <= cts_loss; // see RL14
      tx_cl[CL_UND] <= i_tx_underrun; // see RL16
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_closed_flag <= 1'b0;
    end else if (i_ce) begin
      if (tx_latch) begin
        tx_closed_flag <= 1'b1;
      end else if (ack_tx) begin
        tx_closed_flag <= 1'b0;
      end
    end
  end

  AST_CTS_GATED: assert property (!ctrl[CTL_CTS_GATE] |-> !o_tx_abort) // see RL15
    else $error("transmit aborted with CTS gate disabled");
  AST_CTS_CLOSE: assert property (tx_latch && o_tx_abort
    |=> tx_cl[CL_CTS] && tx_closed_flag) // see RL14
    else $error("CTS loss did not close the transmit frame");
  AST_UNDERRUN: assert property (tx_latch && i_tx_underrun
    |=> tx_cl[CL_UND] ##1 (tx_cl[CL_UND] || !tx_closed_flag)) // see RL16
    else $error("underrun not reported");

  assign o_rx_buffer_closed_flag = rx_closed_flag;
  assign o_tx_buffer_closed_flag = tx_closed_flag;

  // ==========================================================
  // Read port; status has no write path at all
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[BIT_FLAGS] = flags_st;
    stat_word[BIT_IDLE] = idle_st;
    stat_word[RX_CL_MSB -: RX_CL_W] = rx_cl; // see RL22
    stat_word[TX_CL_MSB -: TX_CL_W] = tx_cl; // see RL22
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      OFS_STATUS: next_rdata = stat_word;
      OFS_CTRL: next_rdata[CTL_W-1:0] = ctrl;
      OFS_CLOSED: begin
        next_rdata[ACK_RX] = rx_closed_flag;
        next_rdata[ACK_TX] = tx_closed_flag;
      end
      OFS_MATCH: next_rdata = match_reg;
      OFS_MASK: next_rdata = mask_reg;
      OFS_MAXLEN: next_rdata[15:0] = max_len;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Data stands in the cycle after the read strobe, and holds while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= i_re ? next_rdata : 32'h0000_0000;
    end
  end

  COV_RX_NORMAL: cover property (rx_latch && i_rx_frame_end && !i_rx_crc_bad);
  COV_RX_ABORT: cover property (rx_latch && abort_evt);
  COV_TX_CTS: cover property (tx_latch && cts_loss);
  COV_SET_ACK: cover property (rx_latch && ack_rx && rx_closed_flag);
endmodule
`default_nettype wire

// [tb/hfs_peer.sv]
// Remote HDLC station model driving the receive framer side
`timescale 1ns/1ns
`default_nettype none
module hfs_peer (
  input wire logic i_clk,
  output logic o_bit_valid,
  output logic o_bit,
  output logic o_active,
  output logic o_byte_valid,
  output logic [7:0] o_byte,
  output logic o_frame_end,
  output logic [2:0] o_residue,
  output logic o_crc_bad,
  output logic o_overrun
);
  initial begin
    {o_bit_valid, o_active, o_byte_valid, o_frame_end, o_crc_bad, o_overrun} = 6'h00;
    o_bit = 1'b0;
    o_byte = 8'hA5;
    o_residue = 3'h0;
  end
  // ==========
  // Line bits between frames, msb first
  task automatic line(input logic [7:0] pat, input int reps);
    for (int i = 0; i < 8 * reps; i++) begin
      @(posedge i_clk);
      o_bit_valid <= 1'b1;
      o_bit <= pat[7 - i % 8];
    end
    @(posedge i_clk);
    o_bit_valid <= 1'b0;
    // Released line shows the inverse, never the last bit
    o_bit <= ~o_bit;
  endtask
  // ==========
  // Whole frame; overrun rides on the second byte
  task automatic frame(input logic [7:0] b0, b1, input int len, input logic [2:0] res,
                       input logic crc, ovr);
    @(posedge i_clk);
    o_active <= 1'b1;
    for (int i = 0; i < len; i++) begin
      @(posedge i_clk);
      o_byte_valid <= 1'b1;
      o_byte <= (i == 0) ? b0 : (i == 1) ? b1 : b0 ^ 8'(i);
      o_overrun <= ovr && i == 1;
    end
    @(posedge i_clk);
    o_byte_valid <= 1'b0;
    o_byte <= ~o_byte;
    o_overrun <= 1'b0;
    o_frame_end <= 1'b1;
    o_residue <= res;
    o_crc_bad <= crc;
    @(posedge i_clk);
    o_frame_end <= 1'b0;
    o_active <= 1'b0;
    o_residue <= 3'h0;
    o_crc_bad <= 1'b0;
  endtask
  // ==========
  // One zero so the run starts inside the frame, then eight ones
  task automatic abort_frame();
    @(posedge i_clk);
    o_active <= 1'b1;
    o_bit_valid <= 1'b1;
    o_bit <= 1'b0;
    repeat (8) begin
      @(posedge i_clk);
      o_bit <= 1'b1;
    end
    @(posedge i_clk);
    o_bit_valid <= 1'b0;
    o_bit <= 1'b0;
    o_active <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb_hdlc_frame_status_reporting.sv]
// Self-checking bench for the HDLC frame closure status block
`timescale 1ns/1ns
`default_nettype none
module tb_hdlc_frame_status_reporting
  import hfs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic tx_act = 1'b0;
  logic cts = 1'b1;
  logic tx_end = 1'b0;
  logic tx_und = 1'b0;
  logic tx_abort, rx_flag, tx_flag, bv, bt, act, yv, fe, crcb, ovrf;
  logic [7:0] yb;
  logic [2:0] resd;
  int num_errors = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h0000_0038;
  logic [31:0] mt, mk, d;
  logic [15:0] mx;
  logic [9:0] hold;
  logic [7:0] b0, b1;
  logic [2:0] ctl, rs;
  logic cb, ob;
  int len, j;

  initial begin
    forever #50 clk = ~clk;
  end

  hfs_status DUT (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_we(we), .i_re(re), .o_rdata(rdata), .i_rx_bit_valid(bv), .i_rx_bit(bt),
    .i_rx_active(act), .i_rx_byte_valid(yv), .i_rx_byte(yb), .i_rx_frame_end(fe),
    .i_rx_residue(resd), .i_rx_crc_bad(crcb), .i_rx_overrun(ovrf), .i_tx_active(tx_act),
    .i_cts(cts), .i_tx_frame_end(tx_end), .i_tx_underrun(tx_und), .o_tx_abort(tx_abort),
    .o_rx_buffer_closed_flag(rx_flag), .o_tx_buffer_closed_flag(tx_flag));

  hfs_peer peer (.i_clk(clk), .o_bit_valid(bv), .o_bit(bt), .o_active(act),
    .o_byte_valid(yv), .o_byte(yb), .o_frame_end(fe), .o_residue(resd),
    .o_crc_bad(crcb), .o_overrun(ovrf));

  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic e8(input logic [7:0] a, b, m);
    return ((a ^ b) & ~m) == 8'h00;
  endfunction
  function automatic logic [9:0] exp_rx();
    logic lg;
    lg = len > int'(mx);
    return {e8(b0, mt[31:24], mk[31:24]) && (!ctl[CTL_WIDE_ONE] || e8(b1, mt[23:16], mk[23:16])),
      e8(b0, mt[23:16], mk[23:16]),
      e8(b0, mt[15:8], mk[15:8]) && (!ctl[CTL_WIDE_TWO] || e8(b1, mt[7:0], mk[7:0])),
      e8(b0, mt[7:0], mk[7:0]), !(cb || ob || rs != 3'h0 || lg), cb, ob, rs != 3'h0, lg, 1'b0};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask
  task automatic wait_flag(input logic tx);
    int n;
    n = 0;
    while ((tx ? tx_flag : rx_flag) !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    chk("closed flag", {31'h0, tx ? tx_flag : rx_flag}, 32'h1);
    if (n >= 10) test_done();
  endtask
  task automatic send();
    peer.frame(b0, b1, len, rs, cb, ob);
    wait_flag(1'b0);
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFS_CTRL, 32'(RST_CTRL), "ctrl reset");
    rchk(OFS_MATCH, RST_MATCH, "match reset");
    rchk(OFS_MASK, RST_MASK, "mask reset");
    rchk(OFS_MAXLEN, 32'(RST_MAXLEN), "maxlen reset");
    rchk(OFS_CLOSED, 32'h0, "closed reset");
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(OFS_STATUS, 32'h0, "status read-only");
    rchk(8'h40, 32'h0, "unmapped");
    // Clock enable low must swallow a write
    ce <= 1'b0;
    wr(OFS_MAXLEN, 32'h0000_0001);
    ce <= 1'b1;
    rchk(OFS_MAXLEN, 32'(RST_MAXLEN), "frozen write");
    $display("test registers done");
    peer.line(FLAG_PATTERN, 3);
    rchk(OFS_STATUS, 32'h1 << BIT_FLAGS, "flags seen");
    peer.line(8'hFF, 2);
    rchk(OFS_STATUS, 32'h1 << BIT_IDLE, "idle seen");
    peer.line(FLAG_PATTERN, 1);
    rchk(OFS_STATUS, 32'h1 << BIT_FLAGS, "idle cleared");
    $display("test line status done");
    mx = 16'h0005;
    wr(OFS_MAXLEN, {16'h0000, mx});
    for (int k = 0; k < 24; k++) begin
      ctl = 3'(rnd());
      mt = rnd();
      mk = rnd() & rnd() & rnd();
      j = int'(rnd() % 4);
      b0 = (rnd() % 4 == 0) ? 8'(rnd()) : 8'(mt >> (8 * (3 - j)));
      b1 = (rnd() % 2 == 0) ? 8'(rnd()) : 8'(mt >> (8 * ((6 - j) % 4)));
      len = 2 + int'(rnd() % 6);
      rs = (rnd() % 4 == 0) ? 3'(1 + rnd() % 7) : 3'h0;
      cb = rnd() % 4 == 0;
      ob = rnd() % 4 == 0;
      wr(OFS_CTRL, 32'(ctl));
      wr(OFS_MATCH, mt);
      wr(OFS_MASK, mk);
      send();
      rchk(OFS_STATUS, {4'h0, exp_rx(), 18'h0}, "rx status");
      wr(OFS_CLOSED, 32'h1);
      rchk(OFS_CLOSED, 32'h0, "rx ack");
    end
    $display("test random frames done");
    {ctl, mk, cb, ob, rs} = {3'h0, 32'h0, 2'b00, 3'h0};
    len = 5;
    b0 = mt[31:24];
    wr(OFS_CTRL, 32'h0);
    wr(OFS_MASK, 32'h0);
    send();
    hold = exp_rx();
    cb = 1'b1;
    len = 7;
    peer.frame(8'h00, 8'h00, len, 3'h1, cb, 1'b1);
    rchk(OFS_STATUS, {4'h0, hold, 18'h0}, "held status");
    rchk(OFS_CLOSED, 32'h1, "held flag");
    wr(OFS_CLOSED, 32'h1);
    rchk(OFS_CLOSED, 32'h0, "dropped close");
    peer.abort_frame();
    wait_flag(1'b0);
    rd(OFS_STATUS, d);
    chk("abort bits", 32'(d[23:18]), 32'h1);
    wr(OFS_CLOSED, 32'h1);
    $display("test hold and abort done");
    @(posedge clk);
    tx_act <= 1'b1;
    cts <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("gate off", {30'h0, tx_abort, tx_flag}, 32'h0);
    wr(OFS_CTRL, 32'h1 << CTL_CTS_GATE);
    #1 chk("tx abort", 32'(tx_abort), 32'h1);
    wait_flag(1'b1);
    @(posedge clk);
    cts <= 1'b1;
    rd(OFS_STATUS, d);
    chk("cts loss", 32'(d[15:14]), 32'h2);
    wr(OFS_CLOSED, 32'h2);
    for (int t = 0; t < 2; t++) begin
      @(posedge clk);
      tx_und <= t == 0;
      tx_end <= t == 1;
      @(posedge clk);
      tx_und <= 1'b0;
      tx_end <= 1'b0;
      wait_flag(1'b1);
      rd(OFS_STATUS, d);
      chk("tx closure", 32'(d[15:14]), (t == 0) ? 32'h1 : 32'h0);
      wr(OFS_CLOSED, 32'h2);
      rchk(OFS_CLOSED, 32'h0, "tx ack");
    end
    $display("test transmit done");
    test_done();
  end
endmodule
`default_nettype wire
